// *** verilog/scpr_regs.sv ***
// Per-channel metering cadence and polarity reversal; shared indirect RAM window
`include "scpr_consts.svh"

// How it works
// - Off interval is 16 bits: high byte at 32, low byte at 31, both read/write.
// - Off interval counts in 1.25 us steps per bit.
// - Polarity bit 3 is read-only: 0 forward, 1 reversed.
// - Wink bit 2 steps open-circuit voltage down to 0 V; clear holds it.
// - Bit 1 enables gradual polarity reversal; 0 gives an abrupt one.
// - Bit 0 picks ramp of 1 V or 2 V per 1.25 ms.
// - Data then pointer write stores data at the next memory update.
// - Pointer write alone loads the word into data at next update.
// - 8-bit pointer; 16-bit data, high byte at 102, low at 101.
// - Pointer and data registers are one copy shared by both channels.
// - Status bit 0 is 1 while an access is pending, else 0.
// - Reset clears off-timer high, polarity, data high and RAM status.
// - A 16-bit on interval in the same 1.25 us units exists too.
module scpr_regs
  import scpr_pkg::*;
#(
  parameter int RAMP_STEP_CYCLES  = `SCPR_RAMP_STEP_NS / `SCPR_CLK_PERIOD_NS,
  parameter int MEM_UPDATE_CYCLES = `SCPR_MEM_UPDATE_NS / `SCPR_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  // Register port from the serial control port
  input  wire scpr_reg_req_t     reg_req_i,
  output logic [7:0]             reg_rdata_o,
  output logic                   reg_ack_o,
  // Per-channel line control from the core
  input  wire logic [1:0]        meter_enable_i,
  input  wire logic [1:0]        reverse_req_i,
  input  wire logic [1:0][7:0]   voc_nominal_i,
  // Per-channel line state
  output scpr_line_t [1:0]       line_o
);

  localparam logic [7:0]  METER_LAST =
    8'(`SCPR_METER_LSB_NS / `SCPR_CLK_PERIOD_NS - 1);
  localparam logic [17:0] RAMP_LAST  = 18'(RAMP_STEP_CYCLES - 1);

  function automatic logic hit(input scpr_reg_req_t req, input logic [7:0] off);
    hit = (req.addr == off);
  endfunction

  // ****************************************
  // Shared tick generators
  // ****************************************
  logic [7:0]  meter_cnt_r;
  logic [17:0] ramp_cnt_r;
  logic        meter_tick;
  logic        ramp_tick;

  assign meter_tick = (meter_cnt_r == METER_LAST);
  assign ramp_tick  = (ramp_cnt_r == RAMP_LAST);

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      meter_cnt_r <= `SCPR_RESET_BYTE;
      ramp_cnt_r  <= '0;
    end else begin
      meter_cnt_r <= meter_tick ? `SCPR_RESET_BYTE : meter_cnt_r + 8'h01;
      ramp_cnt_r  <= ramp_tick ? '0 : ramp_cnt_r + 18'h0_0001;
    end
  end

  // ****************************************
  // Shared indirect window
  // ****************************************
  logic [7:0]  pointer_r;
  logic [15:0] word_r;
  logic        data_dirty_r;
  logic        wr_ptr;
  logic        wr_dlo;
  logic        wr_dhi;
  logic        ram_busy;
  logic        ram_done;
  logic [15:0] ram_rdata;

  assign wr_ptr = reg_req_i.wr && hit(reg_req_i, `SCPR_OFF_POINTER);
  assign wr_dlo = reg_req_i.wr && hit(reg_req_i, `SCPR_OFF_DATA_LO);
  assign wr_dhi = reg_req_i.wr && hit(reg_req_i, `SCPR_OFF_DATA_HI);

  // One copy for both channels; the channel select is not decoded here
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pointer_r    <= `SCPR_RESET_BYTE;
      word_r       <= `SCPR_RESET_WORD;
      data_dirty_r <= 1'b0;
    end else begin
      if (wr_ptr) begin
        pointer_r <= reg_req_i.wdata;
      end
      // Read result lands over software bytes; software waits on busy
      if (ram_done) begin
        word_r <= ram_rdata;
      end else begin
        if (wr_dlo) word_r[7:0]  <= reg_req_i.wdata;
        if (wr_dhi) word_r[15:8] <= reg_req_i.wdata;
      end
      // Data write arms a store; a pointer write consumes it
      if (wr_dlo || wr_dhi) begin
        data_dirty_r <= 1'b1;
      end else if (wr_ptr) begin
        data_dirty_r <= 1'b0;
      end
    end
  end

  scpr_ram #(
    .MEM_UPDATE_CYCLES (MEM_UPDATE_CYCLES)
  ) u_ram (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .start_i   (wr_ptr),
    .write_i   (data_dirty_r),
    .addr_i    (reg_req_i.wdata),
    .wdata_i   (word_r),
    .busy_o    (ram_busy),
    .done_o    (ram_done),
    .rdata_o   (ram_rdata)
  );

  // ****************************************
  // Per-channel registers and line engine
  // ****************************************
  logic [1:0][7:0] ch_rdata;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [15:0]      on_r;
    logic [15:0]      off_r;
    logic [2:0]       pol_ctl_r;
    logic             reversed_r;
    logic             phase_on_r;
    logic [15:0]      cad_cnt_r;
    logic [7:0]       mag_r;
    logic signed [7:0] volt_r;
    logic             sel;
    logic             wr_ch;
    logic [15:0]      interval;
    logic             cad_end;
    logic signed [8:0] target;
    logic signed [8:0] diff;
    logic signed [8:0] step;
    logic signed [8:0] ramped;
    logic signed [7:0] volt_nxt;

    assign sel      = (reg_req_i.chan == 1'(c));
    assign wr_ch    = reg_req_i.wr && sel;
    assign interval = phase_on_r ? on_r : off_r;
    assign cad_end  = (cad_cnt_r + 16'h0001 >= interval);
    assign target   = reverse_req_i[c] ? -$signed({1'b0, mag_r})
                                       : $signed({1'b0, mag_r});
    assign diff     = target - 9'(volt_r);
    assign step     = pol_ctl_r[`SCPR_BIT_RAMP] ? `SCPR_RAMP_FAST_V
                                                : `SCPR_RAMP_SLOW_V;
    assign ramped   = (diff > step)  ? 9'(volt_r) + step :
                      (diff < -step) ? 9'(volt_r) - step : target;
    assign volt_nxt = !pol_ctl_r[`SCPR_BIT_GRADUAL] ? 8'(target) :
                      ramp_tick ? 8'(ramped) : volt_r;

    // Register writes
    always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
        on_r      <= `SCPR_RESET_WORD;
        off_r     <= `SCPR_RESET_WORD;
        pol_ctl_r <= 3'h0;
      end else if (wr_ch) begin
        if (hit(reg_req_i, `SCPR_OFF_ON_LO))  on_r[7:0]   <= reg_req_i.wdata;
        if (hit(reg_req_i, `SCPR_OFF_ON_HI))  on_r[15:8]  <= reg_req_i.wdata;
        if (hit(reg_req_i, `SCPR_OFF_OFF_LO)) off_r[7:0]  <= reg_req_i.wdata;
        if (hit(reg_req_i, `SCPR_OFF_OFF_HI)) off_r[15:8] <= reg_req_i.wdata;
        if (hit(reg_req_i, `SCPR_OFF_POLARITY)) begin
          pol_ctl_r <= reg_req_i.wdata[2:0];
        end
      end
    end

    // Metering cadence: on interval, then off interval, repeating
    always_ff @(posedge ref_clk_i) begin
      if (reset_i || !meter_enable_i[c]) begin
        phase_on_r <= 1'b1;
        cad_cnt_r  <= `SCPR_RESET_WORD;
      end else if (meter_tick) begin
        if (cad_end) begin
          phase_on_r <= !phase_on_r;
          cad_cnt_r  <= `SCPR_RESET_WORD;
        end else begin
          cad_cnt_r  <= cad_cnt_r + 16'h0001;
        end
      end
    end

    // Line voltage, wink and polarity state
    always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
        mag_r      <= voc_nominal_i[c];
        volt_r     <= `SCPR_ZERO_VOLT;
        reversed_r <= 1'b0;
      end else begin
        // Wink only steps down; clearing it holds the reached value
        if (pol_ctl_r[`SCPR_BIT_WINK] && ramp_tick && mag_r != 8'h00) begin
          mag_r <= mag_r - 8'h01;
        end
        volt_r <= volt_nxt;
        // Status flips only once the line has reached the new polarity
        if (volt_r == 8'(target)) begin
          reversed_r <= reverse_req_i[c];
        end
      end
    end

    always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
        line_o[c] <= '0;
      end else begin
        line_o[c].tone     <= meter_enable_i[c] && phase_on_r;
        line_o[c].reversed <= reversed_r;
        line_o[c].voltage  <= volt_r;
      end
    end

    // Per-channel read value; reserved polarity bits read zero
    assign ch_rdata[c] =
      hit(reg_req_i, `SCPR_OFF_POLARITY) ?
        {4'h0, reversed_r, pol_ctl_r} :
      hit(reg_req_i, `SCPR_OFF_ON_LO)  ? on_r[7:0]   :
      hit(reg_req_i, `SCPR_OFF_ON_HI)  ? on_r[15:8]  :
      hit(reg_req_i, `SCPR_OFF_OFF_LO) ? off_r[7:0]  :
      hit(reg_req_i, `SCPR_OFF_OFF_HI) ? off_r[15:8] : `SCPR_RESET_BYTE;
  end

  // ****************************************
  // Read mux and answer
  // ****************************************
  logic [7:0] shared_rdata;
  logic [7:0] rdata_nxt;

  assign shared_rdata =
    hit(reg_req_i, `SCPR_OFF_RAM_STATE) ? {7'h00, ram_busy} :
    hit(reg_req_i, `SCPR_OFF_POINTER)   ? pointer_r    :
    hit(reg_req_i, `SCPR_OFF_DATA_LO)   ? word_r[7:0]  :
    hit(reg_req_i, `SCPR_OFF_DATA_HI)   ? word_r[15:8] : `SCPR_RESET_BYTE;
  assign rdata_nxt = shared_rdata | ch_rdata[reg_req_i.chan];

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= `SCPR_RESET_BYTE;
      reg_ack_o   <= 1'b0;
    end else begin
      reg_ack_o   <= reg_req_i.wr || reg_req_i.rd;
      if (reg_req_i.rd) begin
        reg_rdata_o <= rdata_nxt;
      end
    end
  end

endmodule

// *** verilog/scpr_consts.svh ***
// Register offsets, field positions, reset values and timing figures
`ifndef SCPR_CONSTS_SVH
`define SCPR_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define SCPR_OFF_RAM_STATE  8'h04
`define SCPR_OFF_POLARITY   8'h07
`define SCPR_OFF_ON_LO      8'h1D
`define SCPR_OFF_ON_HI      8'h1E
`define SCPR_OFF_OFF_LO     8'h1F
`define SCPR_OFF_OFF_HI     8'h20
`define SCPR_OFF_DATA_LO    8'h65
`define SCPR_OFF_DATA_HI    8'h66
`define SCPR_OFF_POINTER    8'h67

// ****************************************
// Field positions and reset values
// ****************************************
`define SCPR_BIT_RAMP       0
`define SCPR_BIT_GRADUAL    1
`define SCPR_BIT_WINK       2
`define SCPR_BIT_REVERSED   3
`define SCPR_BIT_BUSY       0
`define SCPR_RESET_BYTE     8'h00
`define SCPR_RESET_WORD     16'h0000
`define SCPR_ZERO_VOLT      8'sh00
`define SCPR_RAMP_SLOW_V    9'sh001
`define SCPR_RAMP_FAST_V    9'sh002

// ****************************************
// Timing
// ****************************************
`define SCPR_CLK_PERIOD_NS  10
`define SCPR_METER_LSB_NS   1250
`define SCPR_RAMP_STEP_NS   1250000
`define SCPR_MEM_UPDATE_NS  125000

`endif

// *** verilog/scpr_pkg.sv ***
// Types shared by the register slice and its indirect parameter store
package scpr_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic       chan;
    logic [7:0] wdata;
  } scpr_reg_req_t;

  typedef struct packed {
    logic       tone;
    logic       reversed;
    logic [7:0] voltage;
  } scpr_line_t;

  typedef enum logic [1:0] {
    SCPR_RAM_IDLE,
    SCPR_RAM_READ,
    SCPR_RAM_WRITE
  } scpr_ram_op_t;

endpackage

// *** verilog/scpr_ram.sv ***
// Indirect parameter store with memory update timing
`include "scpr_consts.svh"

module scpr_ram
  import scpr_pkg::*;
#(
  parameter int MEM_UPDATE_CYCLES = `SCPR_MEM_UPDATE_NS / `SCPR_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // Access request
  input  wire logic        start_i,
  input  wire logic        write_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  // Status and read result
  output logic             busy_o,
  output logic             done_o,
  output logic [15:0]      rdata_o
);

  localparam logic [16:0] UPD_LAST = 17'(MEM_UPDATE_CYCLES - 1);

  scpr_ram_op_t op_r;
  scpr_ram_op_t op_nxt;
  logic [16:0]  upd_cnt_r;
  logic [7:0]   addr_r;
  logic [15:0]  data_r;
  logic [15:0]  mem_r [256];
  logic         upd_tick;
  logic         do_write;
  logic         do_read;

  assign upd_tick = (upd_cnt_r == UPD_LAST);
  assign do_write = upd_tick && (op_r == SCPR_RAM_WRITE);
  assign do_read  = upd_tick && (op_r == SCPR_RAM_READ);
  assign busy_o   = (op_r != SCPR_RAM_IDLE);

  // A new request in the update cycle wins over retirement
  always_comb begin
    op_nxt = op_r;
    case (op_r)
      SCPR_RAM_IDLE:  op_nxt = SCPR_RAM_IDLE;
      SCPR_RAM_READ:  op_nxt = upd_tick ? SCPR_RAM_IDLE : SCPR_RAM_READ;
      SCPR_RAM_WRITE: op_nxt = upd_tick ? SCPR_RAM_IDLE : SCPR_RAM_WRITE;
      default:        op_nxt = SCPR_RAM_IDLE;
    endcase
    if (start_i) begin
      op_nxt = write_i ? SCPR_RAM_WRITE : SCPR_RAM_READ;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      op_r      <= SCPR_RAM_IDLE;
      upd_cnt_r <= '0;
      addr_r    <= `SCPR_RESET_BYTE;
      data_r    <= `SCPR_RESET_WORD;
      done_o    <= 1'b0;
      rdata_o   <= `SCPR_RESET_WORD;
    end else begin
      op_r      <= op_nxt;
      upd_cnt_r <= upd_tick ? '0 : upd_cnt_r + 17'h0_0001;
      done_o    <= do_read;
      if (start_i) begin
        addr_r <= addr_i;
        data_r <= wdata_i;
      end
      if (do_read) begin
        rdata_o <= mem_r[addr_r];
      end
    end
  end

  // Storage cleared on hardware reset
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < 256; i++) begin
        mem_r[i] <= `SCPR_RESET_WORD;
      end
    end else if (do_write) begin
      mem_r[addr_r] <= data_r;
    end
  end

endmodule

// *** verification/scpr_regs_chk.sv ***
// Port checker for the register slice
module scpr_regs_chk
  import scpr_pkg::*;
(
  // Clock and reset
  input wire logic             ref_clk_i,
  input wire logic             reset_i,
  // Watched ports
  input wire scpr_reg_req_t    reg_req_i,
  input wire logic [7:0]       reg_rdata_o,
  input wire logic             reg_ack_o,
  input wire logic [1:0]       meter_enable_i,
  input wire logic [1:0]       reverse_req_i,
  input wire logic [1:0][7:0]  voc_nominal_i,
  input wire scpr_line_t [1:0] line_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // Helpers
  // ****
  wire logic       rq_w = reg_req_i.wr | reg_req_i.rd;
  wire logic [7:0] ad_w = reg_req_i.addr;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  ack_follow_a: assert property (rq_w |=> reg_ack_o)
    else $error("ack missing after request");
  ack_quiet_a: assert property (!rq_w |=> !reg_ack_o)
    else $error("ack without request");
  rdata_hold_a: assert property (!reg_req_i.rd |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  pol_rsvd_a: assert property (reg_req_i.rd && ad_w == 8'h07 |=> reg_rdata_o[7:4] == 4'h0)
    else $error("polarity reserved bits set");
  stat_rsvd_a: assert property (reg_req_i.rd && ad_w == 8'h04 |=> reg_rdata_o[7:1] == 7'h00)
    else $error("status reserved bits set");
  busy_set_a: assert property (reg_req_i.wr && ad_w == 8'h67 ##1 reg_req_i.rd && ad_w == 8'h04
    |=> reg_rdata_o[0])
    else $error("busy not set after pointer write");
  timer_back_a: assert property (reg_req_i.wr && ad_w == 8'h20 ##1 reg_req_i.rd && ad_w == 8'h20
    && reg_req_i.chan == $past(reg_req_i.chan) |=> reg_rdata_o == $past(reg_req_i.wdata, 2))
    else $error("off timer high readback wrong");
  tone_idle_a: assert property (!meter_enable_i[0] [*3] |-> !line_o[0].tone)
    else $error("tone on while disabled");
  cover property (reg_req_i.wr && ad_w == 8'h67);
  cover property (reg_req_i.rd && ad_w == 8'h04 ##1 !reg_rdata_o[0]);
  cover property ($rose(line_o[0].tone));
endmodule

bind scpr_regs scpr_regs_chk chk_i (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .meter_enable_i(meter_enable_i),
  .reverse_req_i(reverse_req_i), .voc_nominal_i(voc_nominal_i), .line_o(line_o));

// *** verification/testbench.sv ***
// Self-checking bench for the register slice
module testbench
  import scpr_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic             ref_clk;
  logic             reset;
  scpr_reg_req_t    req;
  logic [7:0]       rdata;
  logic             ack;
  logic [1:0]       meter_en;
  logic [1:0]       rev_req;
  scpr_line_t [1:0] line;
  int               mismatches;
  int               samples_checked;
  int               cycles;
  int               n;
  logic [7:0]       d;

  scpr_regs #(.RAMP_STEP_CYCLES(20), .MEM_UPDATE_CYCLES(16)) dut (
    .ref_clk_i(ref_clk), .reset_i(reset), .reg_req_i(req), .reg_rdata_o(rdata),
    .reg_ack_o(ack), .meter_enable_i(meter_en), .reverse_req_i(rev_req),
    .voc_nominal_i(16'h3030), .line_o(line));

  always #5 ref_clk = ~ref_clk;

  // ****
  // Access and compare tasks
  // ****
  // Request launched one step after an edge, result read after the taking edge
  task automatic acc(input logic w, input logic c, input logic [7:0] a, input logic [7:0] v);
    req = '{addr: a, wr: w, rd: ~w, chan: c, wdata: v};
    @(posedge ref_clk);
    #1;
    d = rdata;
  endtask
  task automatic wr_reg(input logic c, input logic [7:0] a, input logic [7:0] v);
    acc(1'b1, c, a, v);
  endtask
  task automatic rd_reg(input logic c, input logic [7:0] a);
    acc(1'b0, c, a, 8'h00);
  endtask
  task automatic wait_clk(input int k);
    req.wr = 1'b0;
    req.rd = 1'b0;
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Always polls status first; the last data byte read says nothing about busy
  task automatic wait_ram;
    rd_reg(1'b0, 8'h04);
    for (n = 0; n < 20 && d[0] !== 1'b0; n++) rd_reg(1'b0, 8'h04);
    chk("ram idle", 8'h00, d);
  endtask
  // Length of the present tone level on channel 0, bounded
  task automatic span(input logic lvl);
    wait_clk(0);
    for (n = 0; n < 600 && line[0].tone === lvl; n++) wait_clk(1);
  endtask
  task automatic results;
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      results;
    end
  end

  // ****
  // Test sequence
  // ****
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    req = '0;
    meter_en = 2'b00;
    rev_req = 2'b00;
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (6) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    rd_reg(1'b0, 8'h04); chk("status reset", 8'h00, d);
    rd_reg(1'b0, 8'h07); chk("polarity reset", 8'h00, d);
    rd_reg(1'b0, 8'h20); chk("off high reset", 8'h00, d);
    rd_reg(1'b0, 8'h66); chk("data high reset", 8'h00, d);
    $display("Test reset values done");
    wr_reg(1'b1, 8'h1f, 8'h34);
    wr_reg(1'b1, 8'h20, 8'h12);
    rd_reg(1'b1, 8'h20); chk("off high ch1", 8'h12, d);
    wr_reg(1'b0, 8'h20, 8'h00);
    rd_reg(1'b0, 8'h20); chk("off high ch0", 8'h00, d);
    rd_reg(1'b1, 8'h1f); chk("off low ch1", 8'h34, d);
    wr_reg(1'b0, 8'h1f, 8'h01);
    wr_reg(1'b0, 8'h1d, 8'h02);
    wr_reg(1'b0, 8'h1e, 8'h00);
    rd_reg(1'b0, 8'h1d); chk("on low ch0", 8'h02, d);
    wait_clk(1);
    meter_en = 2'b01;
    span(1'b0);
    span(1'b1);
    span(1'b0); chk("off span", 8'h7d, n[7:0]);
    span(1'b1); chk("on span", 8'hfa, n[7:0]);
    meter_en = 2'b00;
    wait_clk(3); chk("tone stopped", 8'h00, {7'h00, line[0].tone});
    $display("Test metering cadence done");
    for (int k = 0; k < 8; k++) begin
      wr_reg(1'b1, 8'h07, 8'hf8 | 8'(k));
      rd_reg(1'b1, 8'h07); chk("polarity code", 8'(k), d);
    end
    wr_reg(1'b0, 8'h07, 8'h03);
    wr_reg(1'b1, 8'h07, 8'h00);
    wait_clk(1);
    rev_req = 2'b11;
    wait_clk(10);
    chk("abrupt reversed", 8'h01, {7'h00, line[1].reversed});
    chk("gradual pending", 8'h00, {7'h00, line[0].reversed});
    rd_reg(1'b1, 8'h07); chk("status reversed", 8'h08, d);
    wait_clk(700); chk("ramp midway", 8'h00, {7'h00, line[0].reversed});
    wait_clk(400); chk("ramp done", 8'h01, {7'h00, line[0].reversed});
    rd_reg(1'b0, 8'h07); chk("status ch0", 8'h0b, d);
    wr_reg(1'b1, 8'h07, 8'h04);
    wait_clk(1100); chk("wink zero", 8'h00, line[1].voltage);
    wr_reg(1'b1, 8'h07, 8'h00);
    wait_clk(60); chk("wink held", 8'h00, line[1].voltage);
    wr_reg(1'b0, 8'h07, 8'h02);
    wait_clk(1);
    rev_req = 2'b10;
    wait_clk(1500); chk("slow ramp midway", 8'h01, {7'h00, line[0].reversed});
    wait_clk(500); chk("slow ramp done", 8'h00, {7'h00, line[0].reversed});
    chk("ch0 forward volts", 8'h30, line[0].voltage);
    $display("Test polarity done");
    wr_reg(1'b1, 8'h66, 8'hbe);
    wr_reg(1'b1, 8'h65, 8'hef);
    wr_reg(1'b1, 8'h67, 8'h05);
    rd_reg(1'b0, 8'h04); chk("busy after write", 8'h01, d);
    wait_ram;
    wr_reg(1'b0, 8'h67, 8'h06);
    rd_reg(1'b0, 8'h65); chk("data before update", 8'hef, d);
    wait_ram;
    rd_reg(1'b0, 8'h65); chk("read low", 8'h00, d);
    wr_reg(1'b0, 8'h67, 8'h05);
    wait_ram;
    rd_reg(1'b0, 8'h66); chk("shared high", 8'hbe, d);
    rd_reg(1'b0, 8'h65); chk("shared low", 8'hef, d);
    wr_reg(1'b0, 8'h04, 8'hff);
    wr_reg(1'b0, 8'h00, 8'hff);
    rd_reg(1'b0, 8'h04); chk("status write ignored", 8'h00, d);
    rd_reg(1'b0, 8'h00); chk("unmapped", 8'h00, d);
    wait_clk(2);
    $display("Test indirect ram done");
    results;
  end
endmodule
